// >>> rtl/rf_timing_pkg.sv
// constants, types and helpers for the rf protocol timing timers
package rf_timing_pkg;

    // clock and step times
    localparam int CLK_PERIOD_PS = 25000;
    localparam int DELAY_STEP_NS = 590;
    localparam int PULSE_STEP_PS = 73700;
    localparam int SILENT_STEP_PS = 37760000;

    // least times round up to whole clock cycles
    function automatic int cycles_up(input int ps);
        return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction

    localparam int DELAY_STEP_CYC = cycles_up(DELAY_STEP_NS * 1000);
    localparam int PULSE_STEP_CYC = cycles_up(PULSE_STEP_PS);
    localparam int SILENT_STEP_CYC = cycles_up(SILENT_STEP_PS);

    // prescaler widths and terminal values
    localparam int DLY_PRE_W = $clog2(DELAY_STEP_CYC);
    localparam int SIL_PRE_W = $clog2(SILENT_STEP_CYC);
    localparam logic [DLY_PRE_W-1:0] DLY_PRE_LAST = DLY_PRE_W'(DELAY_STEP_CYC - 1);
    localparam logic [SIL_PRE_W-1:0] SIL_PRE_LAST = SIL_PRE_W'(SILENT_STEP_CYC - 1);
    localparam int LEN_W = 14;
    localparam int PULSE_W = 10;
    localparam logic [PULSE_W-1:0] PULSE_STEP_W = PULSE_W'(PULSE_STEP_CYC);

    // default modulation pulse widths per protocol
    localparam int PULSE_VIC_NS = 9440;
    localparam int PULSE_A106_NS = 2360;
    localparam int PULSE_A212_NS = 1400;
    localparam int PULSE_A424_NS = 737;
    localparam int PULSE_A848_NS = 442;

    // no-response presets, register value rounded to nearest step
    localparam int SIL_VIC_HI_US = 755;
    localparam int SIL_VIC_LO_US = 1812;
    localparam int SIL_OTHER_US = 529;
    function automatic logic [7:0] silent_steps(input int us);
        return 8'((us * 1000000 + SILENT_STEP_PS / 2) / SILENT_STEP_PS);
    endfunction

    // register offsets
    localparam logic [7:0] OFS_PROTO = 8'h01;
    localparam logic [7:0] OFS_DLY_HI = 8'h04;
    localparam logic [7:0] OFS_DLY_LO = 8'h05;
    localparam logic [7:0] OFS_PULSE = 8'h06;
    localparam logic [7:0] OFS_SILENT = 8'h07;

    // reset values
    localparam logic [7:0] PROTO_RST = 8'h00;
    localparam logic [7:0] DLY_HI_RST = 8'hC2;
    localparam logic [7:0] DLY_LO_RST = 8'h00;
    localparam logic [7:0] PULSE_RST = 8'h00;
    localparam logic [7:0] SILENT_RST = 8'h0E;

    // field positions
    localparam int ORIGIN_MSB = 7;
    localparam int ORIGIN_LSB = 6;
    localparam int DLY_HI_LEN_MSB = 5;
    localparam int PROTO_MSB = 2;

    typedef enum logic [1:0] {
        ORG_TX_SOF_BEGIN,
        ORG_TX_SOF_END,
        ORG_RX_SOF_BEGIN,
        ORG_RX_SOF_END
    } origin_e;

    typedef enum logic [2:0] {
        PROTO_VIC_HI,
        PROTO_VIC_LO,
        PROTO_A106,
        PROTO_A212,
        PROTO_A424,
        PROTO_A848,
        PROTO_OTHER
    } proto_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic tx_sof_begin;
        logic tx_sof_end;
        logic rx_sof_begin;
        logic rx_sof_end;
        logic tx_eof_done;
        logic tx_complete;
        logic fifo_reset;
        logic mod_request;
    } frame_evt_s;

endpackage

// >>> rtl/rf_timing_timers.sv
// protocol timing timers: delayed transmission, pulse width, no-response
//
// Contract
// [R1] transmission starts after length times 590 ns
// [R2] zero length means no delay
// [R3] low length byte clears on reset sources
// [R4] zero override uses protocol pulse width
// [R5] nonzero override gives value times 73.7 ns
// [R6] protocol selection sets default pulse widths
// [R7] override register clears on reset sources
// [R8] timer spans slot start to reply start
// [R9] expiry raises interrupt and sets flag
// [R10] no-response value counts 37.76 us steps
// [R11] counting starts when own EOF completes
// [R12] no-response interrupt only in vicinity protocol
// [R13] protocol selection presets no-response time
// [R14] no-response register resets to 0x0E
// [R15] buffer reset after tx complete cancels detection
// [R16] upper six length bits in high byte
// [R17] two-bit field selects delay start point
// [R18] high byte resets to 0xC2
// [R19] steps from integer division; values apply next frame
// [R20] reply start stops timer without interrupt
`timescale 1ns/1ps

module rf_timing_timers
    import rf_timing_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic en_pin,
    input wire reg_req_s bus,
    output logic [7:0] reg_rdata,
    input wire frame_evt_s evt,
    input wire logic flag_clear,
    output logic tx_start,
    output logic mod_pulse,
    output logic silent_irq,
    output logic silent_flag
);

    typedef enum logic {DLY_IDLE, DLY_RUN} dly_state_e;
    typedef enum logic {SIL_IDLE, SIL_RUN} sil_state_e;

    // decode the written protocol code, unknown codes fall to other
    function automatic proto_e decode_proto(input logic [PROTO_MSB:0] code);
        case (code)
            3'h0: return PROTO_VIC_HI;
            3'h1: return PROTO_VIC_LO;
            3'h2: return PROTO_A106;
            3'h3: return PROTO_A212;
            3'h4: return PROTO_A424;
            3'h5: return PROTO_A848;
            default: return PROTO_OTHER;
        endcase
    endfunction

    // protocol default pulse width in clock cycles
    function automatic logic [PULSE_W-1:0] pulse_default(input proto_e p);
        case (p)
            PROTO_VIC_HI, PROTO_VIC_LO: return PULSE_W'(cycles_up(PULSE_VIC_NS * 1000));
            PROTO_A212: return PULSE_W'(cycles_up(PULSE_A212_NS * 1000));
            PROTO_A424: return PULSE_W'(cycles_up(PULSE_A424_NS * 1000));
            PROTO_A848: return PULSE_W'(cycles_up(PULSE_A848_NS * 1000));
            default: return PULSE_W'(cycles_up(PULSE_A106_NS * 1000));
        endcase
    endfunction

    // no-response preset per protocol
    function automatic logic [7:0] silent_preset(input proto_e p);
        case (p)
            PROTO_VIC_HI: return silent_steps(SIL_VIC_HI_US);
            PROTO_VIC_LO: return silent_steps(SIL_VIC_LO_US);
            default: return silent_steps(SIL_OTHER_US);
        endcase
    endfunction

    logic [2:0] en_sync_r;
    logic en_level_r;
    proto_e proto_r;
    logic [7:0] dly_hi_r;
    logic [7:0] dly_lo_r;
    logic [7:0] pulse_r;
    logic [7:0] silent_r;
    logic [7:0] reg_rdata_r;
    logic proto_wr;
    logic wr_ok;
    logic hold_default;
    logic [LEN_W-1:0] delay_count;
    origin_e delay_origin;
    logic origin_hit;

    // enable pin: three stages, level changes once stages two and three agree
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            en_sync_r <= 3'h0;
        else
            en_sync_r <= {en_sync_r[1:0], en_pin};
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            en_level_r <= 1'b0;
        else if (en_sync_r[1] == en_sync_r[2])
            en_level_r <= en_sync_r[2];
    end

    // writes other than the protocol register are dropped while the enable is low since defaults are forced then
    assign proto_wr = bus.wr && bus.addr == OFS_PROTO;
    assign wr_ok = bus.wr && en_level_r;
    assign hold_default = !en_level_r;

    // protocol selection register
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            proto_r <= decode_proto(PROTO_RST[PROTO_MSB:0]);
        else if (proto_wr)
            proto_r <= decode_proto(bus.wdata[PROTO_MSB:0]);
    end

    // delay high byte: start origin and upper length bits
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            dly_hi_r <= DLY_HI_RST; // [R18]
        else if (hold_default || proto_wr)
            dly_hi_r <= DLY_HI_RST; // [R18]
        else if (wr_ok && bus.addr == OFS_DLY_HI)
            dly_hi_r <= bus.wdata; // [R16] [R17]
    end

    // delay low byte
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            dly_lo_r <= DLY_LO_RST; // [R3]
        else if (hold_default || proto_wr)
            dly_lo_r <= DLY_LO_RST; // [R3]
        else if (wr_ok && bus.addr == OFS_DLY_LO)
            dly_lo_r <= bus.wdata;
    end

    // pulse width override
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            pulse_r <= PULSE_RST; // [R7]
        else if (hold_default || proto_wr)
            pulse_r <= PULSE_RST; // [R7]
        else if (wr_ok && bus.addr == OFS_PULSE)
            pulse_r <= bus.wdata;
    end

    // no-response time: fixed default when disabled, protocol preset on selection
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            silent_r <= SILENT_RST; // [R14]
        else if (hold_default)
            silent_r <= SILENT_RST; // [R14]
        else if (proto_wr)
            silent_r <= silent_preset(decode_proto(bus.wdata[PROTO_MSB:0])); // [R13]
        else if (wr_ok && bus.addr == OFS_SILENT)
            silent_r <= bus.wdata;
    end

    // read port, data valid the cycle after the strobe, zero elsewhere
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata_r <= 8'h00;
        else if (!bus.rd)
            reg_rdata_r <= 8'h00;
        else if (bus.addr == OFS_PROTO)
            reg_rdata_r <= {{(7 - PROTO_MSB){1'b0}}, proto_r};
        else if (bus.addr == OFS_DLY_HI)
            reg_rdata_r <= dly_hi_r;
        else if (bus.addr == OFS_DLY_LO)
            reg_rdata_r <= dly_lo_r;
        else if (bus.addr == OFS_PULSE)
            reg_rdata_r <= pulse_r;
        else if (bus.addr == OFS_SILENT)
            reg_rdata_r <= silent_r;
        else
            reg_rdata_r <= 8'h00;
    end

    assign reg_rdata = reg_rdata_r;

    // delayed transmission timer
    dly_state_e dly_state_r;
    logic [DLY_PRE_W-1:0] dly_pre_r;
    logic [LEN_W-1:0] dly_step_r;
    logic [LEN_W-1:0] dly_len_r;
    logic tx_start_r;

    assign delay_count = {dly_hi_r[DLY_HI_LEN_MSB:0], dly_lo_r}; // [R16]
    assign delay_origin = origin_e'(dly_hi_r[ORIGIN_MSB:ORIGIN_LSB]);

    // pick the frame event that starts the delay
    always_comb
    begin
        case (delay_origin)
            ORG_TX_SOF_BEGIN: origin_hit = evt.tx_sof_begin; // [R17]
            ORG_TX_SOF_END: origin_hit = evt.tx_sof_end; // [R17]
            ORG_RX_SOF_BEGIN: origin_hit = evt.rx_sof_begin; // [R17]
            default: origin_hit = evt.rx_sof_end; // [R17]
        endcase
    end

    // length is latched at the origin so a later write waits for the next frame
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dly_state_r <= DLY_IDLE;
            dly_pre_r <= '0;
            dly_step_r <= '0;
            dly_len_r <= '0;
            tx_start_r <= 1'b0;
        end
        else
        begin
            tx_start_r <= 1'b0;
            case (dly_state_r)
                DLY_IDLE:
                begin
                    dly_pre_r <= '0;
                    dly_step_r <= '0;
                    if (origin_hit && !hold_default)
                    begin
                        dly_len_r <= delay_count; // [R19]
                        if (delay_count == '0)
                            tx_start_r <= 1'b1; // [R2]
                        else
                            dly_state_r <= DLY_RUN;
                    end
                end
                DLY_RUN:
                begin
                    if (hold_default || proto_wr)
                        dly_state_r <= DLY_IDLE;
                    else if (dly_pre_r == DLY_PRE_LAST) // [R19]
                    begin
                        dly_pre_r <= '0;
                        if (dly_step_r == dly_len_r - LEN_W'(1))
                        begin
                            tx_start_r <= 1'b1; // [R1]
                            dly_state_r <= DLY_IDLE;
                        end
                        else
                            dly_step_r <= dly_step_r + LEN_W'(1); // [R1]
                    end
                    else
                        dly_pre_r <= dly_pre_r + DLY_PRE_W'(1);
                end
                default: dly_state_r <= DLY_IDLE;
            endcase
        end
    end

    assign tx_start = tx_start_r;

    // modulation pulse generator; width fixed when the pulse starts
    logic [PULSE_W-1:0] pulse_cnt_r;
    logic mod_pulse_r;
    logic [PULSE_W-1:0] pulse_width;

    assign pulse_width = (pulse_r != 8'h00)
        ? PULSE_W'(pulse_r) * PULSE_STEP_W // [R5]
        : pulse_default(proto_r); // [R4] [R6]

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pulse_cnt_r <= '0;
            mod_pulse_r <= 1'b0;
        end
        else if (hold_default)
        begin
            pulse_cnt_r <= '0;
            mod_pulse_r <= 1'b0;
        end
        else if (!mod_pulse_r && evt.mod_request)
        begin
            pulse_cnt_r <= pulse_width - PULSE_W'(1);
            mod_pulse_r <= 1'b1;
        end
        else if (mod_pulse_r)
        begin
            if (pulse_cnt_r == '0)
                mod_pulse_r <= 1'b0;
            else
                pulse_cnt_r <= pulse_cnt_r - PULSE_W'(1);
        end
    end

    assign mod_pulse = mod_pulse_r;

    // no-response timer for empty anticollision slots
    sil_state_e sil_state_r;
    logic [SIL_PRE_W-1:0] sil_pre_r;
    logic [7:0] sil_step_r;
    logic [7:0] sil_len_r;
    logic txc_seen_r;
    logic silent_irq_r;
    logic silent_flag_r;
    logic vicinity;
    logic sil_expire;

    assign vicinity = proto_r == PROTO_VIC_HI || proto_r == PROTO_VIC_LO;
    assign sil_expire = sil_state_r == SIL_RUN && sil_pre_r == SIL_PRE_LAST
        && sil_step_r == sil_len_r - 8'h01 && !evt.rx_sof_begin;

    // zero setting is outside the valid range, so no detection is armed
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sil_state_r <= SIL_IDLE;
            sil_pre_r <= '0;
            sil_step_r <= 8'h00;
            sil_len_r <= 8'h00;
            txc_seen_r <= 1'b0;
        end
        else
        begin
            case (sil_state_r)
                SIL_IDLE:
                begin
                    sil_pre_r <= '0;
                    sil_step_r <= 8'h00;
                    txc_seen_r <= 1'b0;
                    if (evt.tx_eof_done && vicinity && silent_r != 8'h00 && !hold_default) // [R11] [R12]
                    begin
                        sil_len_r <= silent_r; // [R10] [R19]
                        sil_state_r <= SIL_RUN; // [R8]
                    end
                end
                SIL_RUN:
                begin
                    if (evt.tx_complete)
                        txc_seen_r <= 1'b1;
                    if (evt.rx_sof_begin)
                        sil_state_r <= SIL_IDLE; // [R8] [R20]
                    else if (evt.fifo_reset && txc_seen_r)
                        sil_state_r <= SIL_IDLE; // [R15]
                    else if (hold_default || proto_wr || !vicinity)
                        sil_state_r <= SIL_IDLE; // [R12]
                    else if (sil_expire)
                        sil_state_r <= SIL_IDLE; // [R9]
                    else if (sil_pre_r == SIL_PRE_LAST) // [R10]
                    begin
                        sil_pre_r <= '0;
                        sil_step_r <= sil_step_r + 8'h01;
                    end
                    else
                        sil_pre_r <= sil_pre_r + SIL_PRE_W'(1);
                end
                default: sil_state_r <= SIL_IDLE;
            endcase
        end
    end

    // expiry is qualified by the same cancel terms as the state update
    logic sil_fire;
    assign sil_fire = sil_expire && !(evt.fifo_reset && txc_seen_r)
        && !hold_default && !proto_wr && vicinity;

    // one-cycle interrupt request on an empty slot
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            silent_irq_r <= 1'b0;
        else
            silent_irq_r <= sil_fire; // [R9]
    end

    // sticky flag, a new expiry wins over a clear in the same cycle
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            silent_flag_r <= 1'b0;
        else if (sil_fire)
            silent_flag_r <= 1'b1; // [R9]
        else if (flag_clear)
            silent_flag_r <= 1'b0;
    end

    assign silent_irq = silent_irq_r;
    assign silent_flag = silent_flag_r;

endmodule // rf_timing_timers

// >>> test/host_model.sv
// host controller model driving the register port
`timescale 1ns/1ps
module host_model
    import rf_timing_pkg::*;
(
    input wire logic mclk,
    input wire logic [7:0] reg_rdata,
    output reg_req_s bus
);
    // idle bus from time zero
    initial bus = '0;

    // one-cycle write strobe, idle cycle before the next request
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '0;
    endtask

    // data stands only in the cycle after the strobe, so take it there
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '0;
        // answer launched on this edge; take it once settled, within its only cycle
        #1;
        d = reg_rdata;
    endtask
endmodule // host_model

// >>> test/rf_timing_timers_properties.sv
// assertions on the ports of the rf protocol timing timers
`timescale 1ns/1ps
module rf_timing_timers_props
    import rf_timing_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic en_pin,
    input wire reg_req_s bus,
    input wire logic [7:0] reg_rdata,
    input wire frame_evt_s evt,
    input wire logic flag_clear,
    input wire logic tx_start,
    input wire logic mod_pulse,
    input wire logic silent_irq,
    input wire logic silent_flag
);
    // single clock domain, reset masks every check
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // interrupt request is a single-cycle pulse
    property p_irq_pulse;
        silent_irq |=> !silent_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("no-response request longer than one cycle");

    // flag is set together with the request
    property p_irq_flag;
        silent_irq |-> silent_flag;
    endproperty
    a_irq_flag: assert property (p_irq_flag)
        else $error("request without flag");

    // clear drops the flag unless a new expiry lands at once
    property p_flag_clear;
        flag_clear |=> (silent_flag == silent_irq);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag clear misbehaved");

    // a reply start wins over an expiry in the same cycle
    property p_reply_stop;
        evt.rx_sof_begin |=> !silent_irq;
    endproperty
    a_reply_stop: assert property (p_reply_stop)
        else $error("request after reply start");

    // transmission start is a single-cycle pulse
    property p_tx_single;
        tx_start |=> !tx_start;
    endproperty
    a_tx_single: assert property (p_tx_single)
        else $error("transmit start longer than one cycle");

    // shortest pulse is one override step of three cycles
    property p_mod_hold;
        $rose(mod_pulse) |-> mod_pulse [*3];
    endproperty
    a_mod_hold: assert property (p_mod_hold)
        else $error("modulation pulse too short");

    // a pulse only follows a request
    property p_mod_cause;
        $rose(mod_pulse) |-> $past(evt.mod_request);
    endproperty
    a_mod_cause: assert property (p_mod_cause)
        else $error("modulation pulse without request");

    // read data is zero outside the answer cycle
    property p_rd_idle;
        !bus.rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside answer cycle");
endmodule // rf_timing_timers_props

// >>> test/testbench.sv
// self-checking bench for the rf protocol timing timers
`timescale 1ns/1ps
module testbench
    import rf_timing_pkg::*;
;
    localparam int DSTEP = (590000 + 24999) / 25000;
    localparam int PSTEP = (73700 + 24999) / 25000;
    localparam int SSTEP = (37760000 + 24999) / 25000;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic en_pin = 1'b1;
    logic flag_clear = 1'b0;
    frame_evt_s evt = '0;
    reg_req_s bus;
    logic [7:0] reg_rdata;
    logic tx_start, mod_pulse, silent_irq, silent_flag;
    logic [7:0] m [0:255];
    logic [7:0] d;
    int pns [8] = '{9440, 9440, 2360, 1400, 737, 442, 2360, 2360};
    int failures = 0;
    int n_checks = 0;
    int k, wd, n, v;

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    rf_timing_timers dut_u (.mclk(mclk), .sys_rst(sys_rst), .en_pin(en_pin), .bus(bus), .reg_rdata(reg_rdata),
        .evt(evt), .flag_clear(flag_clear), .tx_start(tx_start), .mod_pulse(mod_pulse),
        .silent_irq(silent_irq), .silent_flag(silent_flag));
    host_model host_u (.mclk(mclk), .reg_rdata(reg_rdata), .bus(bus));

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cyc(input int got, input int exp);
        n_checks++;
        if (got != exp)
        begin
            failures++;
            $display("[ERR] %0t cycles %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // no-response preset rounded to the nearest step
    function automatic logic [7:0] preset(input int p);
        int us;
        us = (p == 0) ? 755 : (p == 1) ? 1812 : 529;
        return 8'((us * 100 + 1888) / 3776);
    endfunction

    // write through the host and mirror it in the model
    task automatic wreg(input logic [7:0] a, input logic [7:0] dat);
        host_u.wr(a, dat);
        if (a == 8'h01)
        begin
            // codes 6 and 7 both read back as the single other-protocol code
            m[1] = (dat[2:0] == 3'h7) ? 8'h06 : {5'h00, dat[2:0]};
            m[4] = 8'hC2;
            m[5] = 8'h00;
            m[6] = 8'h00;
            m[7] = preset(dat[2:0]);
        end
        else if (a >= 8'h04 && a <= 8'h07)
            m[a] = dat;
    endtask

    // read every mapped place plus an unmapped one
    task automatic sweep;
        logic [7:0] al [6] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h3F};
        foreach (al[i])
        begin
            host_u.rd(al[i], d);
            chk_reg(d, m[al[i]]);
        end
    endtask

    // pulse one event, count edges until the chosen output is seen
    task automatic measure(input logic [7:0] b, input int sel, input int lim, output int cnt);
        logic [2:0] o;
        @(posedge mclk);
        evt <= frame_evt_s'(b);
        @(posedge mclk);
        evt <= '0;
        cnt = -1;
        for (int i = 1; i <= lim && cnt < 0; i++)
        begin
            @(posedge mclk);
            o = {silent_irq, mod_pulse, tx_start};
            if (o[sel] === 1'b1)
                cnt = i;
        end
    endtask

    // main sequence
    initial
    begin
        m = '{default: 8'h00};
        m[4] = 8'hC2;
        m[7] = 8'h0E;
        v = $urandom(53);
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge mclk);
        sweep();
        $display("test reset done");
        // random contents, then every protocol code
        for (int p = 0; p < 8; p++)
        begin
            for (int a = 4; a < 8; a++)
                wreg(8'(a), 8'($urandom));
            wreg(8'h3F, 8'hA5);
            sweep();
            wreg(8'h01, 8'(p));
            sweep();
        end
        $display("test registers done");
        // enable pin low forces defaults
        wreg(8'h05, 8'h5A);
        wreg(8'h06, 8'h11);
        en_pin <= 1'b0;
        repeat (8) @(posedge mclk);
        en_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        m[4] = 8'hC2;
        m[5] = 8'h00;
        m[6] = 8'h00;
        m[7] = 8'h0E;
        sweep();
        $display("test enable done");
        // delayed transmission from each start origin
        wreg(8'h01, 8'h00);
        for (int o = 0; o < 4; o++)
        begin
            n = (o == 0) ? 0 : (o == 3) ? 257 : $urandom_range(20, 1);
            wreg(8'h04, {2'(o), 6'(n >> 8)});
            wreg(8'h05, 8'(n));
            measure(8'h80 >> o, 0, 7000, k);
            chk_cyc(k, n * DSTEP + 1);
        end
        $display("test delay done");
        // pulse widths: protocol defaults, then random and top override
        for (int p = 0; p < 10; p++)
        begin
            if (p < 8)
                wreg(8'h01, 8'(p));
            else
                wreg(8'h06, (p == 8) ? 8'($urandom_range(254, 1)) : 8'hFF);
            measure(8'h01, 1, 5, k);
            chk_cyc(k, 1);
            wd = 0;
            while (wd < 900 && mod_pulse === 1'b1)
            begin
                @(posedge mclk);
                wd++;
            end
            chk_cyc(wd, (m[6] != 0) ? m[6] * PSTEP : (pns[m[1]] * 1000 + 24999) / 25000);
        end
        $display("test pulse done");
        // no-response expiry and flag handling
        v = $urandom_range(3, 1);
        wreg(8'h01, 8'h00);
        wreg(8'h07, 8'(v));
        measure(8'h08, 2, 5000, k);
        chk_cyc(k, v * SSTEP + 1);
        chk_reg({7'h00, silent_flag}, 8'h01);
        flag_clear <= 1'b1;
        @(posedge mclk);
        flag_clear <= 1'b0;
        @(posedge mclk);
        chk_reg({7'h00, silent_flag}, 8'h00);
        // reply start stops the timer quietly
        wreg(8'h07, 8'h01);
        measure(8'h08, 2, 100, k);
        measure(8'h20, 2, 1600, k);
        chk_cyc(k, -1);
        // buffer reset after transmit complete cancels detection
        measure(8'h08, 2, 100, k);
        measure(8'h04, 2, 5, k);
        measure(8'h02, 2, 1600, k);
        chk_cyc(k, -1);
        // outside the vicinity protocol no request at all
        wreg(8'h01, 8'h02);
        wreg(8'h07, 8'h01);
        measure(8'h08, 2, 1600, k);
        chk_cyc(k, -1);
        $display("test no-response done");
        print_verdict();
    end

    // watchdog, about two to three times the expected run length
    initial
    begin
        #1ms;
        failures++;
        print_verdict();
    end
endmodule // testbench

bind rf_timing_timers rf_timing_timers_props chk_u (.mclk(mclk), .sys_rst(sys_rst), .en_pin(en_pin), .bus(bus),
    .reg_rdata(reg_rdata), .evt(evt), .flag_clear(flag_clear), .tx_start(tx_start), .mod_pulse(mod_pulse),
    .silent_irq(silent_irq), .silent_flag(silent_flag));
